// file: swrb_pkg.sv
// swrb_pkg: constants, states and register map of the reset and boot-mode block
// assumes one 250 MHz clock and AXI4-Lite register access with 32-bit data
// Contract
// - while the fundamental reset input is low, every internal element is held in its reset state; the pin synchroniser and halt_seen keep sampling.
// - a reset-halt seen during the fundamental reset keeps the device quasi-reset with both management buses alive.
// - in the quasi-reset state the internal registers can be read and written over the management bus.
// - the outside master clears the halt bit in the switch control register and the device then starts running.
// - mode 0x0 is single partition, 0x1 adds eeprom init, 0x2 and 0x3 add eeprom init from jump 0 or jump 1.
// - modes 0x4 to 0x7 are reserved and select no operating mode.
// - mode 0x8 is reduced-latency single partition and 0x9 adds eeprom init to it.
// - modes 0xA to 0xD are multi-partition with unattached ports, 0xB adds bus reset, 0xC eeprom, 0xD both.
// - modes 0xE and 0xF are multi-partition with unassigned ports disabled.
// - frequency select low means a 100 MHz reference, high means 125 MHz.
// - the port clocking mode follows the two-bit clock-mode strap.
// - each of the four port stacks takes its configuration from its own strap.
package swrb_pkg;
  // ---------------------------------------------------------------
  // synchronised pin vector layout
  // ---------------------------------------------------------------
  localparam int PIN_W = 13;
  localparam int PIN_FRST = 12;
  localparam int PIN_HALT = 11;
  localparam int PIN_MODE_LSB = 7;
  localparam int PIN_FSEL = 6;
  localparam int PIN_CLKM_LSB = 4;
  localparam int PIN_STK_LSB = 0;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STRAP = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_SCRATCH = 8'h0C;
  localparam logic [1:0] IDX_CTRL = 2'h0;
  localparam logic [1:0] IDX_STRAP = 2'h1;
  localparam logic [1:0] IDX_STATUS = 2'h2;
  localparam logic [1:0] IDX_SCRATCH = 2'h3;
  localparam int CTRL_HALT = 0;
  localparam int STRAP_CLKM_LSB = 4;
  localparam int STRAP_FSEL = 6;
  localparam int STRAP_STK_LSB = 8;
  localparam int STAT_QUASI = 2;
  localparam int STAT_RUN = 3;
  localparam int STAT_RSVD = 4;
  localparam logic [31:0] SCRATCH_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ---------------------------------------------------------------
  // switch modes and reference clock
  // ---------------------------------------------------------------
  localparam logic [3:0] MODE_SINGLE = 4'h0;
  localparam logic [3:0] MODE_SINGLE_EE = 4'h1;
  localparam logic [3:0] MODE_JUMP0 = 4'h2;
  localparam logic [3:0] MODE_JUMP1 = 4'h3;
  localparam logic [3:0] MODE_RSVD_LO = 4'h4;
  localparam logic [3:0] MODE_RSVD_HI = 4'h7;
  localparam logic [3:0] MODE_LOWLAT = 4'h8;
  localparam logic [3:0] MODE_LOWLAT_EE = 4'h9;
  localparam logic [3:0] MODE_MULTI = 4'hA;
  localparam logic [3:0] MODE_MULTI_RST = 4'hB;
  localparam logic [3:0] MODE_MULTI_EE = 4'hC;
  localparam logic [3:0] MODE_MULTI_RST_EE = 4'hD;
  localparam logic [3:0] MODE_MULTI_DIS = 4'hE;
  localparam logic [3:0] MODE_MULTI_DIS_B = 4'hF;
  localparam logic [7:0] REFCLK_LO_MHZ = 8'h64;
  localparam logic [7:0] REFCLK_HI_MHZ = 8'h7D;
  typedef enum logic [1:0] {ST_RESET = 2'h0, ST_CAPTURE = 2'h1, ST_HALT = 2'h3, ST_RUN = 2'h2} swrb_state_e;
endpackage

// file: swrb_mode_if.sv
// swrb_mode_if: switch-mode strap and its decoded operating fields
// assumes the top drives mode and the decoder answers combinationally
`timescale 1ns/1ps
interface swrb_mode_if;
  logic [3:0] mode;
  logic single_part;
  logic multi_part;
  logic eeprom_init;
  logic eeprom_jump0;
  logic eeprom_jump1;
  logic reduced_latency;
  logic bus_reset;
  logic ports_disabled;
  logic reserved;
  modport dec (input mode, output single_part, multi_part, eeprom_init, eeprom_jump0, eeprom_jump1,
               reduced_latency, bus_reset, ports_disabled, reserved);
  modport host (output mode, input single_part, multi_part, eeprom_init, eeprom_jump0, eeprom_jump1,
               reduced_latency, bus_reset, ports_disabled, reserved);
endinterface

// file: swrb_mode_dec.sv
// swrb_mode_dec: combinational decode of the four-bit switch-mode strap
// assumes the caller registers the fields at strap capture
`timescale 1ns/1ps
module swrb_mode_dec (
  swrb_mode_if.dec m
);
  always_comb
  begin
    m.single_part = 1'b0;
    m.multi_part = 1'b0;
    m.eeprom_init = 1'b0;
    m.eeprom_jump0 = 1'b0;
    m.eeprom_jump1 = 1'b0;
    m.reduced_latency = 1'b0;
    m.bus_reset = 1'b0;
    m.ports_disabled = 1'b0;
    m.reserved = 1'b0;
    unique case (m.mode) inside
      swrb_pkg::MODE_SINGLE: m.single_part = 1'b1;
      swrb_pkg::MODE_SINGLE_EE:
      begin
        m.single_part = 1'b1;
        m.eeprom_init = 1'b1;
      end
      swrb_pkg::MODE_JUMP0:
      begin
        m.single_part = 1'b1;
        m.eeprom_jump0 = 1'b1;
      end
      swrb_pkg::MODE_JUMP1:
      begin
        m.single_part = 1'b1;
        m.eeprom_jump1 = 1'b1;
      end
      [swrb_pkg::MODE_RSVD_LO:swrb_pkg::MODE_RSVD_HI]: m.reserved = 1'b1;
      swrb_pkg::MODE_LOWLAT, swrb_pkg::MODE_LOWLAT_EE:
      begin
        m.single_part = 1'b1;
        m.reduced_latency = 1'b1;
        m.eeprom_init = m.mode[0];
      end
      swrb_pkg::MODE_MULTI, swrb_pkg::MODE_MULTI_RST, swrb_pkg::MODE_MULTI_EE, swrb_pkg::MODE_MULTI_RST_EE:
      begin
        m.multi_part = 1'b1;
        m.bus_reset = m.mode[0];
        m.eeprom_init = (m.mode == swrb_pkg::MODE_MULTI_EE) || (m.mode == swrb_pkg::MODE_MULTI_RST_EE);
      end
      swrb_pkg::MODE_MULTI_DIS, swrb_pkg::MODE_MULTI_DIS_B:
      begin
        m.multi_part = 1'b1;
        m.ports_disabled = 1'b1;
      end
    endcase
  end
endmodule

// file: swrb_top.sv
// swrb_top: fundamental reset, reset halt and boot strap capture with an AXI4-Lite register port
// assumes strap and reset pins are asynchronous to aclk; aresetn is synchronous to aclk
//
// Our own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module swrb_top #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic fundamental_reset_n,
  input wire logic reset_halt,
  input wire logic [3:0] switch_mode_strap,
  input wire logic global_refclk_freq_select,
  input wire logic [1:0] port_clocking_mode,
  input wire logic stack0_config_strap,
  input wire logic stack1_config_strap,
  input wire logic stack2_config_strap,
  input wire logic stack3_config_strap,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic quasi_reset,
  output logic normal_operation,
  output logic smbus_active,
  output logic mode_single_partition,
  output logic mode_multi_partition,
  output logic mode_eeprom_init,
  output logic mode_eeprom_jump0,
  output logic mode_eeprom_jump1,
  output logic mode_reduced_latency,
  output logic mode_bus_reset,
  output logic mode_ports_disabled,
  output logic mode_reserved,
  output logic refclk_is_125,
  output logic [7:0] refclk_mhz,
  output logic [1:0] port_clk_mode,
  output logic [3:0] stack_config
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ---------------------------------------------------------------
  // pin synchroniser
  // ---------------------------------------------------------------
  logic [swrb_pkg::PIN_W-1:0] pin_raw;
  logic [swrb_pkg::PIN_W-1:0] pin_meta;
  logic [swrb_pkg::PIN_W-1:0] pin_sync;
  logic frst_n_s;
  logic halt_s;
  logic rst_int;

  assign pin_raw = {fundamental_reset_n, reset_halt, switch_mode_strap, global_refclk_freq_select,
                    port_clocking_mode, stack3_config_strap, stack2_config_strap,
                    stack1_config_strap, stack0_config_strap};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
    end
    else
    begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  assign frst_n_s = pin_sync[swrb_pkg::PIN_FRST];
  assign halt_s = pin_sync[swrb_pkg::PIN_HALT];
  // fundamental reset folds into the local reset
  assign rst_int = !aresetn || !frst_n_s;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  swrb_pkg::swrb_state_e state;
  swrb_pkg::swrb_state_e next_state;
  logic halt_seen;
  logic ctrl_halt;

  always_comb
  begin
    next_state = state;
    unique case (state)
      swrb_pkg::ST_RESET: next_state = swrb_pkg::ST_CAPTURE;
      swrb_pkg::ST_CAPTURE: next_state = (halt_seen || halt_s) ? swrb_pkg::ST_HALT : swrb_pkg::ST_RUN;
      swrb_pkg::ST_HALT: next_state = ctrl_halt ? swrb_pkg::ST_HALT : swrb_pkg::ST_RUN;
      swrb_pkg::ST_RUN: next_state = swrb_pkg::ST_RUN;
    endcase
    if (rst_int)
      next_state = swrb_pkg::ST_RESET;
  end

  always_ff @(posedge aclk)
  begin
    if (rst_int)
      state <= swrb_pkg::ST_RESET;
    else
      state <= next_state;
  end

  // halt request remembered over the whole reset sequence
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      halt_seen <= 1'b0;
    else if (rst_int)
      halt_seen <= halt_seen || halt_s;
    else if (state == swrb_pkg::ST_CAPTURE)
      halt_seen <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (rst_int)
    begin
      quasi_reset <= 1'b0;
      normal_operation <= 1'b0;
      smbus_active <= 1'b0;
    end
    else
    begin
      quasi_reset <= next_state == swrb_pkg::ST_HALT;
      normal_operation <= next_state == swrb_pkg::ST_RUN;
      smbus_active <= next_state == swrb_pkg::ST_HALT || next_state == swrb_pkg::ST_RUN;
    end
  end

  // ---------------------------------------------------------------
  // strap capture
  // ---------------------------------------------------------------
  swrb_mode_if u_mif ();
  logic [3:0] cap_mode;

  assign u_mif.mode = pin_sync[swrb_pkg::PIN_MODE_LSB +: 4];

  swrb_mode_dec u_dec (
    .m(u_mif)
  );

  // straps are assumed still after release, so one sample suffices
  always_ff @(posedge aclk)
  begin
    if (rst_int)
    begin
      cap_mode <= 4'h0;
      port_clk_mode <= 2'h0;
      stack_config <= 4'h0;
      refclk_is_125 <= 1'b0;
      refclk_mhz <= 8'h00;
      mode_single_partition <= 1'b0;
      mode_multi_partition <= 1'b0;
      mode_eeprom_init <= 1'b0;
      mode_eeprom_jump0 <= 1'b0;
      mode_eeprom_jump1 <= 1'b0;
      mode_reduced_latency <= 1'b0;
      mode_bus_reset <= 1'b0;
      mode_ports_disabled <= 1'b0;
      mode_reserved <= 1'b0;
    end
    else if (state == swrb_pkg::ST_CAPTURE)
    begin
      cap_mode <= u_mif.mode;
      port_clk_mode <= pin_sync[swrb_pkg::PIN_CLKM_LSB +: 2];
      stack_config <= pin_sync[swrb_pkg::PIN_STK_LSB +: 4];
      refclk_is_125 <= pin_sync[swrb_pkg::PIN_FSEL];
      refclk_mhz <= pin_sync[swrb_pkg::PIN_FSEL] ? swrb_pkg::REFCLK_HI_MHZ : swrb_pkg::REFCLK_LO_MHZ;
      mode_single_partition <= u_mif.single_part;
      mode_multi_partition <= u_mif.multi_part;
      mode_eeprom_init <= u_mif.eeprom_init;
      mode_eeprom_jump0 <= u_mif.eeprom_jump0;
      mode_eeprom_jump1 <= u_mif.eeprom_jump1;
      mode_reduced_latency <= u_mif.reduced_latency;
      mode_bus_reset <= u_mif.bus_reset;
      mode_ports_disabled <= u_mif.ports_disabled;
      mode_reserved <= u_mif.reserved;
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  logic aw_full;
  logic w_full;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [31:0] scratch;
  logic [31:0] rd_word;
  logic [2:0] wr_sel;
  logic [2:0] rd_sel;
  logic do_write;
  logic aw_take;
  logic w_take;
  logic b_take;
  logic ar_take;
  logic r_take;

  // {hit, index} of an address
  function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] a);
    logic [7:0] low;
    low = a[7:0] & 8'hFC;
    if ((a >> 8) != '0)
      return 3'h0;
    unique case (low)
      swrb_pkg::OFF_CTRL: return {1'b1, swrb_pkg::IDX_CTRL};
      swrb_pkg::OFF_STRAP: return {1'b1, swrb_pkg::IDX_STRAP};
      swrb_pkg::OFF_STATUS: return {1'b1, swrb_pkg::IDX_STATUS};
      swrb_pkg::OFF_SCRATCH: return {1'b1, swrb_pkg::IDX_SCRATCH};
      default: return 3'h0;
    endcase
  endfunction

  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign b_take = s_axi_bvalid && s_axi_bready;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign r_take = s_axi_rvalid && s_axi_rready;
  assign do_write = aw_full && w_full && !s_axi_bvalid;
  assign wr_sel = reg_index(wr_addr);
  assign rd_sel = reg_index(s_axi_araddr);

  always_ff @(posedge aclk)
  begin
    if (rst_int)
    begin
      aw_full <= 1'b0;
      s_axi_awready <= 1'b0;
      wr_addr <= '0;
    end
    else if (aw_take)
    begin
      aw_full <= 1'b1;
      s_axi_awready <= 1'b0;
      wr_addr <= s_axi_awaddr;
    end
    else if (b_take)
    begin
      aw_full <= 1'b0;
      s_axi_awready <= 1'b1;
    end
    else
      s_axi_awready <= !aw_full;
  end

  always_ff @(posedge aclk)
  begin
    if (rst_int)
    begin
      w_full <= 1'b0;
      s_axi_wready <= 1'b0;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end
    else if (w_take)
    begin
      w_full <= 1'b1;
      s_axi_wready <= 1'b0;
      wr_data <= s_axi_wdata;
      wr_strb <= s_axi_wstrb;
    end
    else if (b_take)
    begin
      w_full <= 1'b0;
      s_axi_wready <= 1'b1;
    end
    else
      s_axi_wready <= !w_full;
  end

  always_ff @(posedge aclk)
  begin
    if (rst_int)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= swrb_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_sel[2] ? swrb_pkg::RESP_OKAY : swrb_pkg::RESP_SLVERR;
    end
    else if (b_take)
      s_axi_bvalid <= 1'b0;
  end

  // halt bit: set on entering quasi-reset, cleared only by writing zero
  always_ff @(posedge aclk)
  begin
    if (rst_int)
      ctrl_halt <= 1'b0;
    else if (state == swrb_pkg::ST_CAPTURE && next_state == swrb_pkg::ST_HALT)
      ctrl_halt <= 1'b1;
    else if (do_write && wr_sel == {1'b1, swrb_pkg::IDX_CTRL} && wr_strb[0] && !wr_data[swrb_pkg::CTRL_HALT])
      ctrl_halt <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (rst_int)
      scratch <= swrb_pkg::SCRATCH_RESET;
    else if (do_write && wr_sel == {1'b1, swrb_pkg::IDX_SCRATCH})
      for (int b = 0; b < 4; b++)
        if (wr_strb[b])
          scratch[b*8 +: 8] <= wr_data[b*8 +: 8];
  end

  always_comb
  begin
    rd_word = 32'h0000_0000;
    unique case (rd_sel)
      {1'b1, swrb_pkg::IDX_CTRL}: rd_word[swrb_pkg::CTRL_HALT] = ctrl_halt;
      {1'b1, swrb_pkg::IDX_STRAP}:
      begin
        rd_word[3:0] = cap_mode;
        rd_word[swrb_pkg::STRAP_CLKM_LSB +: 2] = port_clk_mode;
        rd_word[swrb_pkg::STRAP_FSEL] = refclk_is_125;
        rd_word[swrb_pkg::STRAP_STK_LSB +: 4] = stack_config;
      end
      {1'b1, swrb_pkg::IDX_STATUS}:
      begin
        rd_word[1:0] = state;
        rd_word[swrb_pkg::STAT_QUASI] = quasi_reset;
        rd_word[swrb_pkg::STAT_RUN] = normal_operation;
        rd_word[swrb_pkg::STAT_RSVD] = mode_reserved;
      end
      {1'b1, swrb_pkg::IDX_SCRATCH}: rd_word = scratch;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (rst_int)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= swrb_pkg::RESP_OKAY;
    end
    else if (ar_take)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_sel[2] ? swrb_pkg::RESP_OKAY : swrb_pkg::RESP_SLVERR;
    end
    else if (r_take)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
    else
      s_axi_arready <= !s_axi_rvalid;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_halt_capture;
    state == swrb_pkg::ST_CAPTURE && !rst_int && (halt_seen || halt_s);
  endsequence

  sequence s_scratch_write;
    do_write && !rst_int && wr_sel == {1'b1, swrb_pkg::IDX_SCRATCH} && wr_strb == 4'hF && quasi_reset;
  endsequence

  a_reset_holds_all: assert property (rst_int |=> state == swrb_pkg::ST_RESET && !smbus_active
    && !ctrl_halt && scratch == swrb_pkg::SCRATCH_RESET && !s_axi_bvalid)
    else $error("fundamental reset did not clear internal state");
  a_halt_enters_quasi: assert property (s_halt_capture |=> quasi_reset && smbus_active && ctrl_halt
    && !normal_operation)
    else $error("reset halt did not hold the device in quasi-reset");
  a_halt_bus_write: assert property (s_scratch_write
    |=> scratch == $past(wr_data) && s_axi_bvalid && s_axi_bresp == swrb_pkg::RESP_OKAY)
    else $error("register write in quasi-reset was lost");
  a_halt_release_run: assert property (state == swrb_pkg::ST_HALT && !ctrl_halt && !rst_int
    |=> normal_operation && !quasi_reset && smbus_active)
    else $error("clearing the halt bit did not start normal operation");
  a_strap_capture: assert property (state == swrb_pkg::ST_CAPTURE && !rst_int
    |=> port_clk_mode == $past(pin_sync[swrb_pkg::PIN_CLKM_LSB +: 2])
    && stack_config == $past(pin_sync[swrb_pkg::PIN_STK_LSB +: 4]) ##1 $stable(stack_config) || rst_int)
    else $error("straps not captured at reset release");
  a_single_jump: assert property (smbus_active && cap_mode == swrb_pkg::MODE_JUMP1
    |-> mode_single_partition && mode_eeprom_jump1 && !mode_eeprom_jump0 && !mode_multi_partition)
    else $error("jump 1 mode decoded wrongly");
  a_mode_reserved: assert property (smbus_active && cap_mode[3:2] == 2'h1
    |-> mode_reserved && !mode_single_partition && !mode_multi_partition)
    else $error("reserved mode selected an operating mode");
  a_low_latency: assert property (smbus_active && cap_mode == swrb_pkg::MODE_LOWLAT_EE
    |-> mode_reduced_latency && mode_eeprom_init && mode_single_partition)
    else $error("reduced latency mode decoded wrongly");
  a_multi_unattached: assert property (smbus_active && cap_mode == swrb_pkg::MODE_MULTI_RST_EE
    |-> mode_multi_partition && mode_bus_reset && mode_eeprom_init && !mode_ports_disabled)
    else $error("unattached multi-partition mode decoded wrongly");
  a_multi_disabled: assert property (smbus_active && cap_mode[3:1] == 3'h7
    |-> mode_multi_partition && mode_ports_disabled && !mode_bus_reset)
    else $error("disabled-port multi-partition mode decoded wrongly");
  a_refclk_select: assert property (smbus_active
    |-> refclk_mhz == (refclk_is_125 ? swrb_pkg::REFCLK_HI_MHZ : swrb_pkg::REFCLK_LO_MHZ))
    else $error("reference clock frequency disagrees with select");
endmodule

// file: swrb_board.sv
// swrb_board: board strap model facing the block
// assumes the bench gives the wanted mode and the fundamental reset level
`timescale 1ns/1ps
module swrb_board (
  input wire logic aclk,
  input wire logic fundamental_reset_n,
  input wire logic [3:0] mode_req,
  output logic [3:0] switch_mode_strap
);
  initial switch_mode_strap = 4'h0;
  // mode pins move only while the fundamental reset is low
  always @(posedge aclk)
  begin
    if (!fundamental_reset_n)
    begin
      switch_mode_strap <= mode_req;
    end
  end
endmodule

// file: swrb_top_bench.sv
// swrb_top_bench: strap decode, reset halt and register access tests
// assumes swrb_pkg, swrb_top and swrb_board are compiled first
`timescale 1ns/1ps
module swrb_top_bench;
  logic aclk = 0, aresetn = 0, frst_n = 0, halt = 0, fsel = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0;
  logic [3:0] mode_req = 4'h0, stk = 4'h0, mode_pin;
  logic [1:0] clkm = 2'h0, bresp, rresp;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [1:0] rsp;
  logic awready, wready, bvalid, arready, rvalid, quasi, run, smb, rc125;
  wire [8:0] dec;
  logic [7:0] mhz;
  logic [1:0] pclk;
  logic [3:0] stk_o;
  int err_count = 0, num_checks = 0, cyc = 0;
  initial forever #2 aclk = ~aclk;
  swrb_board brd_u (.aclk(aclk), .fundamental_reset_n(frst_n), .mode_req(mode_req), .switch_mode_strap(mode_pin));
  swrb_top dut_u (.aclk(aclk), .aresetn(aresetn), .fundamental_reset_n(frst_n), .reset_halt(halt),
    .switch_mode_strap(mode_pin), .global_refclk_freq_select(fsel), .port_clocking_mode(clkm),
    .stack0_config_strap(stk[0]), .stack1_config_strap(stk[1]), .stack2_config_strap(stk[2]),
    .stack3_config_strap(stk[3]), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .quasi_reset(quasi), .normal_operation(run), .smbus_active(smb), .mode_single_partition(dec[8]),
    .mode_multi_partition(dec[7]), .mode_eeprom_init(dec[6]), .mode_eeprom_jump0(dec[5]),
    .mode_eeprom_jump1(dec[4]), .mode_reduced_latency(dec[3]), .mode_bus_reset(dec[2]),
    .mode_ports_disabled(dec[1]), .mode_reserved(dec[0]), .refclk_is_125(rc125), .refclk_mhz(mhz),
    .port_clk_mode(pclk), .stack_config(stk_o));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    logic ta, tw;
    ta = 0;
    tw = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(ta && tw))
    begin
      @(posedge aclk);
      if (!ta && awready === 1'b1)
      begin
        ta = 1;
        awvalid <= 0;
      end
      if (!tw && wready === 1'b1)
      begin
        tw = 1;
        wvalid <= 0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    v = rdata;
    r = rresp;
    rready <= 0;
  endtask
  function automatic logic [8:0] exp_dec(input logic [3:0] m);
    exp_dec = {m <= 3 || m == 8 || m == 9, m >= 10, m == 1 || m == 9 || m == 12 || m == 13, m == 2, m == 3,
      m == 8 || m == 9, m == 11 || m == 13, m >= 14, m >= 4 && m <= 7};
  endfunction
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc > 8000)
    begin
      err_count++;
      end_sim();
    end
  end
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    for (int i = 0; i < 16; i++)
    begin
      @(posedge aclk);
      frst_n <= 0;
      mode_req <= i[3:0];
      halt <= i[0];
      fsel <= i[1];
      clkm <= i[2:1];
      stk <= ~i[3:0];
      repeat (4) @(posedge aclk);
      chk({run, quasi, smb, awready, arready, stk_o}, 32'h0);
      frst_n <= 1;
      halt <= 0;
      repeat (6) @(posedge aclk);
      chk(dec & ((i == 2 || i == 3) ? 9'h1BF : 9'h1FF), exp_dec(i[3:0]));
      chk({rc125, mhz}, i[1] ? {1'b1, swrb_pkg::REFCLK_HI_MHZ} : {1'b0, swrb_pkg::REFCLK_LO_MHZ});
      fsel <= ~i[1];
      clkm <= ~i[2:1];
      stk <= i[3:0];
      repeat (4) @(posedge aclk);
      chk({pclk, stk_o, rc125}, {i[2:1], ~i[3:0], i[1]});
      chk({quasi, run, smb}, {i[0], ~i[0], 1'b1});
      if (i[0])
      begin
        axr(swrb_pkg::OFF_SCRATCH, d, rsp);
        chk(d, swrb_pkg::SCRATCH_RESET);
        axw(swrb_pkg::OFF_SCRATCH, 32'hA5C3_0F1E ^ i, rsp);
        chk(rsp, swrb_pkg::RESP_OKAY);
        axr(swrb_pkg::OFF_SCRATCH, d, rsp);
        chk({rsp, d}, {swrb_pkg::RESP_OKAY, 32'hA5C3_0F1E ^ i});
        axr(8'h10, d, rsp);
        chk(rsp, swrb_pkg::RESP_SLVERR);
        axr(swrb_pkg::OFF_STRAP, d, rsp);
        chk(d, {20'h0, ~i[3:0], 1'b0, i[1], i[2:1], i[3:0]});
        axr(swrb_pkg::OFF_STATUS, d, rsp);
        chk(d, {27'h0, i >= 4 && i <= 7, 1'b0, 1'b1, 2'h3});
        axw(swrb_pkg::OFF_CTRL, 32'h1, rsp);
        repeat (3) @(posedge aclk);
        chk({quasi, run}, 2'h2);
        axr(swrb_pkg::OFF_CTRL, d, rsp);
        chk(d, 32'h1);
        axw(swrb_pkg::OFF_CTRL, 32'h0, rsp);
        repeat (3) @(posedge aclk);
        chk({quasi, run, smb}, 3'h3);
      end
    end
    end_sim();
  end
endmodule
